// ### shared/fcq_pkg.sv
// Constants, types and helpers for the 18-bit clocked first-in first-out buffer.
// Contract
// - Words of 18 bits enter the input port and leave the output port.
// - Depth is a build parameter: 256, 512, 1024, 2048 or 4096 words.
// - A word is stored on each clock edge with write enable low.
// - Write requests are ignored while the buffer is full.
// - Each clock edge with read enable low advances the next word out.
// - With read enable high the output register keeps its word, except while a fall-through first word is loaded.
// - Read requests are ignored while empty; pointer and output hold.
// - Output data is driven only while output enable is low.
// - Reset returns pointers home, full, almost-full and half-full high, others low.
// - Load and write enable low store input bits 11..0 as an offset.
// - Load and read enable low put an offset on output bits 11..0.
// - Standard mode: a first word shows only after an explicit read.
// - Fall-through mode: a first word shows after three read clock edges.
// - A half-full flag output is provided for single device use.
// - A small state machine steps offset loads across load accesses.
// - Works with read and write sharing one clock.
// - Empty and full flags pass through one or two register stages.
// - Almost flags are registered or direct, with default offsets.
// - First-load and both expansion inputs select timing and flag mode.
// - Default offsets: 31 at 256, 63 at 512, 127 for larger depths.
// - Fall-through: empty means output ready, full means input ready.
// - Half-full goes low when more than half the capacity is held.
package fcq_pkg;
  localparam int DATA_W      = 18;
  localparam int OFS_W       = 12;
  localparam int DEPTH_DEF   = 256;
  localparam int DEPTH_SMALL = 256;
  localparam int DEPTH_MID   = 512;
  localparam int OFS_SMALL   = 31;
  localparam int OFS_MID     = 63;
  localparam int OFS_LARGE   = 127;
  localparam int FALL_THROUGH_MODE_EDGES  = 3;
  localparam int CMP_W       = 16;
  localparam int AXI_AW      = 4;
  localparam logic [AXI_AW-1:0] REG_CTRL      = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STATUS    = 4'h4;
  localparam logic [AXI_AW-1:0] REG_EMPTY_OFS = 4'h8;
  localparam logic [AXI_AW-1:0] REG_FULL_OFS  = 4'hC;
  localparam int CTRL_DOUBLE_BIT = 0;
  localparam logic CTRL_DOUBLE_RST = 1'b0;
  localparam int ST_DATA_BIT  = 0;
  localparam int ST_SPACE_BIT = 1;
  localparam int ST_AE_BIT    = 2;
  localparam int ST_AF_BIT    = 3;
  localparam int ST_HF_BIT    = 4;
  localparam int ST_FALL_THROUGH_MODE_BIT  = 5;
  localparam int ST_SYNC_BIT  = 6;
  localparam int ST_CNT_LSB   = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {FCQ_SEL_EMPTY, FCQ_SEL_FULL} fcq_ofs_sel_t;

  function automatic logic [OFS_W-1:0] fcq_default_offset(input int depth);
    if (depth <= DEPTH_SMALL) begin
      return OFS_W'(OFS_SMALL);
    end else if (depth <= DEPTH_MID) begin
      return OFS_W'(OFS_MID);
    end
    return OFS_W'(OFS_LARGE);
  endfunction

  function automatic logic fcq_is_mapped(input logic [AXI_AW-1:0] addr);
    return (addr == REG_CTRL) || (addr == REG_STATUS) ||
           (addr == REG_EMPTY_OFS) || (addr == REG_FULL_OFS);
  endfunction
endpackage

// ### core/fcq_fifo.sv
// Clocked 18-bit first-in first-out buffer with flags and AXI4-Lite status.
`timescale 1ns/1ns
`default_nettype none
module fcq_fifo #(
  parameter int DEPTH = fcq_pkg::DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                        I_SYS_CLK,
  input  wire logic                        I_ARST_N,
  // Write port
  input  wire logic [fcq_pkg::DATA_W-1:0]  I_WRITE_DATA,
  input  wire logic                        I_WRITE_EN_N,
  input  wire logic                        I_OFFSET_LOAD_N,
  // Read port
  input  wire logic                        I_READ_EN_N,
  input  wire logic                        I_OUTPUT_EN_N,
  output logic      [fcq_pkg::DATA_W-1:0]  O_READ_DATA,
  output logic                             O_READ_DATA_OE,
  // Mode selection straps
  input  wire logic                        I_FIRST_LOAD_N,
  input  wire logic                        I_WRITE_EXPANSION_IN_N,
  input  wire logic                        I_READ_EXPANSION_IN_N,
  // Flags
  output logic                             O_EMPTY_OR_OUTPUT_READY,
  output logic                             O_FULL_OR_INPUT_READY,
  output logic                             O_ALMOST_EMPTY_N,
  output logic                             O_ALMOST_FULL_N,
  output logic                             O_HALF_FULL_N,
  // AXI4-Lite slave
  input  wire logic [fcq_pkg::AXI_AW-1:0]  I_AXI_AWADDR,
  input  wire logic                        I_AXI_AWVALID,
  output logic                             O_AXI_AWREADY,
  input  wire logic [31:0]                 I_AXI_WDATA,
  input  wire logic [3:0]                  I_AXI_WSTRB,
  input  wire logic                        I_AXI_WVALID,
  output logic                             O_AXI_WREADY,
  output logic      [1:0]                  O_AXI_BRESP,
  output logic                             O_AXI_BVALID,
  input  wire logic                        I_AXI_BREADY,
  input  wire logic [fcq_pkg::AXI_AW-1:0]  I_AXI_ARADDR,
  input  wire logic                        I_AXI_ARVALID,
  output logic                             O_AXI_ARREADY,
  output logic      [31:0]                 O_AXI_RDATA,
  output logic      [1:0]                  O_AXI_RRESP,
  output logic                             O_AXI_RVALID,
  input  wire logic                        I_AXI_RREADY
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int DW = fcq_pkg::DATA_W;
  localparam int OW = fcq_pkg::OFS_W;
  localparam int QW = fcq_pkg::CMP_W;
  localparam logic [OW-1:0] OFS_DEF = fcq_pkg::fcq_default_offset(DEPTH);
  logic [DW-1:0]        mem [DEPTH];
  logic [AW-1:0]        wptr_reg;
  logic [AW-1:0]        rptr_reg;
  logic [CW-1:0]        count_reg;
  logic [DW-1:0]        out_reg;
  logic                 out_valid_reg;
  logic [1:0]           fall_cnt_reg;
  logic                 cfg_done_reg;
  logic                 fall_through_mode_reg;
  logic                 sync_flags_reg;
  logic [OW-1:0]        empty_ofs_reg;
  logic [OW-1:0]        full_ofs_reg;
  fcq_pkg::fcq_ofs_sel_t ofs_sel_reg;
  logic                 double_reg;
  logic                 data1_reg;
  logic                 data2_reg;
  logic                 space1_reg;
  logic                 space2_reg;
  logic                 ae_reg;
  logic                 af_reg;
  logic                 mem_full;
  logic                 mem_empty;
  logic                 load_wr;
  logic                 load_rd;
  logic                 do_write;
  logic                 std_read;
  logic                 fall_through_mode_take;
  logic                 fall_load;
  logic                 pop;
  logic [QW-1:0]        total;
  logic [QW-1:0]        free_space;
  logic                 ae_now_n;
  logic                 af_now_n;
  logic                 half_n;
  logic                 data_now;
  logic [OW-1:0]        ofs_shown;

  //////////////////////////////////////////////////////////////////////////
  // Request decode.
  assign mem_full  = (count_reg == CW'(DEPTH));
  assign mem_empty = (count_reg == '0);
  assign load_wr   = !I_OFFSET_LOAD_N && !I_WRITE_EN_N;
  assign load_rd   = !I_OFFSET_LOAD_N && !I_READ_EN_N;
  assign do_write  = !I_WRITE_EN_N && I_OFFSET_LOAD_N && !mem_full;
  assign std_read  = !fall_through_mode_reg && !I_READ_EN_N && I_OFFSET_LOAD_N &&
                     !mem_empty;
  assign fall_through_mode_take = fall_through_mode_reg && !I_READ_EN_N && I_OFFSET_LOAD_N &&
                     out_valid_reg;
  // A word drains at once behind a taken word; an idle output waits edges.
  assign fall_load = fall_through_mode_reg && !mem_empty &&
                     (out_valid_reg ? fall_through_mode_take :
                      (fall_cnt_reg == 2'(fcq_pkg::FALL_THROUGH_MODE_EDGES - 1)));
  assign pop       = std_read || fall_load;
  assign ofs_shown = (ofs_sel_reg == fcq_pkg::FCQ_SEL_EMPTY) ?
                     empty_ofs_reg : full_ofs_reg;

  //////////////////////////////////////////////////////////////////////////
  // Mode capture: straps are read once after reset release and held.
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg_done_reg   <= 1'b0;
      fall_through_mode_reg       <= 1'b0;
      sync_flags_reg <= 1'b0;
    end else if (!cfg_done_reg) begin
      cfg_done_reg   <= 1'b1;
      fall_through_mode_reg       <= !I_FIRST_LOAD_N;
      sync_flags_reg <= (I_WRITE_EXPANSION_IN_N == I_READ_EXPANSION_IN_N);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Storage and pointers. Read and write share one clock, so the count
  // is exact and needs no pointer crossing.
  always_ff @(posedge I_SYS_CLK) begin
    if (do_write) begin
      mem[wptr_reg] <= I_WRITE_DATA;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (do_write) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (do_write && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !do_write) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output register.
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      out_reg       <= '0;
      out_valid_reg <= 1'b0;
      fall_cnt_reg  <= '0;
    end else begin
      if (load_rd) begin
        out_reg <= {{(DW - OW){1'b0}}, ofs_shown};
      end else if (pop) begin
        out_reg <= mem[rptr_reg];
      end
      if (fall_load) begin
        out_valid_reg <= 1'b1;
      end else if (fall_through_mode_take) begin
        out_valid_reg <= 1'b0;
      end
      if (fall_through_mode_reg && !out_valid_reg && !mem_empty && !fall_load) begin
        fall_cnt_reg <= fall_cnt_reg + 1'b1;
      end else begin
        fall_cnt_reg <= '0;
      end
    end
  end
  assign O_READ_DATA    = out_reg;
  assign O_READ_DATA_OE = !I_OUTPUT_EN_N;

  //////////////////////////////////////////////////////////////////////////
  // Offset registers, their load sequencer and software access.
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [fcq_pkg::AXI_AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [fcq_pkg::AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_commit;
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      empty_ofs_reg <= OFS_DEF;
      full_ofs_reg  <= OFS_DEF;
      ofs_sel_reg   <= fcq_pkg::FCQ_SEL_EMPTY;
      double_reg    <= fcq_pkg::CTRL_DOUBLE_RST;
    end else begin
      if (wr_commit) begin
        case (wr_addr)
          fcq_pkg::REG_CTRL:
            if (wr_strb[0]) double_reg <= wr_data[fcq_pkg::CTRL_DOUBLE_BIT];
          fcq_pkg::REG_EMPTY_OFS: begin
            if (wr_strb[0]) empty_ofs_reg[7:0] <= wr_data[7:0];
            if (wr_strb[1]) empty_ofs_reg[OW-1:8] <= wr_data[OW-1:8];
          end
          fcq_pkg::REG_FULL_OFS: begin
            if (wr_strb[0]) full_ofs_reg[7:0] <= wr_data[7:0];
            if (wr_strb[1]) full_ofs_reg[OW-1:8] <= wr_data[OW-1:8];
          end
          default: begin
          end
        endcase
      end
      // The pin path is placed last so that it wins over software.
      if (load_wr || load_rd) begin
        case (ofs_sel_reg)
          fcq_pkg::FCQ_SEL_EMPTY: begin
            if (load_wr) empty_ofs_reg <= I_WRITE_DATA[OW-1:0];
            ofs_sel_reg <= fcq_pkg::FCQ_SEL_FULL;
          end
          default: begin
            if (load_wr) full_ofs_reg <= I_WRITE_DATA[OW-1:0];
            ofs_sel_reg <= fcq_pkg::FCQ_SEL_EMPTY;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags.
  assign total      = QW'(count_reg) + QW'(out_valid_reg);
  assign free_space = QW'(DEPTH) - QW'(count_reg);
  assign ae_now_n   = !(total <= QW'(empty_ofs_reg));
  assign af_now_n   = !(free_space <= QW'(full_ofs_reg));
  assign half_n     = !(total > QW'(DEPTH / 2));
  assign data_now   = fall_through_mode_reg ? out_valid_reg : !mem_empty;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      data1_reg  <= 1'b0;
      data2_reg  <= 1'b0;
      space1_reg <= 1'b1;
      space2_reg <= 1'b1;
      ae_reg     <= 1'b0;
      af_reg     <= 1'b1;
    end else begin
      data1_reg  <= data_now;
      data2_reg  <= data1_reg;
      space1_reg <= !mem_full;
      space2_reg <= space1_reg;
      ae_reg     <= ae_now_n;
      af_reg     <= af_now_n;
    end
  end
  // The second stage adds a cycle of flag latency for extra settling.
  assign O_EMPTY_OR_OUTPUT_READY = double_reg ? data2_reg : data1_reg;
  assign O_FULL_OR_INPUT_READY   = double_reg ? space2_reg : space1_reg;
  assign O_ALMOST_EMPTY_N = sync_flags_reg ? ae_reg : ae_now_n;
  assign O_ALMOST_FULL_N  = sync_flags_reg ? af_reg : af_now_n;
  assign O_HALF_FULL_N    = half_n;

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one write and one read at a time.
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status;
  assign O_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
  assign O_AXI_WREADY  = !w_hold_reg && !bvalid_reg;
  assign wr_addr   = aw_hold_reg ? aw_addr_reg : I_AXI_AWADDR;
  assign wr_data   = w_hold_reg ? w_data_reg : I_AXI_WDATA;
  assign wr_strb   = w_hold_reg ? w_strb_reg : I_AXI_WSTRB;
  assign wr_commit = !bvalid_reg &&
                     (aw_hold_reg || I_AXI_AWVALID) &&
                     (w_hold_reg || I_AXI_WVALID);

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= fcq_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      bvalid_reg  <= 1'b1;
      bresp_reg   <= fcq_pkg::fcq_is_mapped(wr_addr) ?
                     fcq_pkg::RESP_OKAY : fcq_pkg::RESP_SLVERR;
    end else begin
      if (I_AXI_AWVALID && O_AXI_AWREADY) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && O_AXI_WREADY) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= I_AXI_WDATA;
        w_strb_reg <= I_AXI_WSTRB;
      end
      if (bvalid_reg && I_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    status = '0;
    status[fcq_pkg::ST_DATA_BIT]  = data_now;
    status[fcq_pkg::ST_SPACE_BIT] = !mem_full;
    status[fcq_pkg::ST_AE_BIT]    = ae_now_n;
    status[fcq_pkg::ST_AF_BIT]    = af_now_n;
    status[fcq_pkg::ST_HF_BIT]    = half_n;
    status[fcq_pkg::ST_FALL_THROUGH_MODE_BIT]  = fall_through_mode_reg;
    status[fcq_pkg::ST_SYNC_BIT]  = sync_flags_reg;
    status[fcq_pkg::ST_CNT_LSB +: QW] = total;
  end

  assign O_AXI_ARREADY = !rvalid_reg;
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= fcq_pkg::RESP_OKAY;
      rdata_reg  <= '0;
    end else if (I_AXI_ARVALID && O_AXI_ARREADY) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= fcq_pkg::fcq_is_mapped(I_AXI_ARADDR) ?
                    fcq_pkg::RESP_OKAY : fcq_pkg::RESP_SLVERR;
      case (I_AXI_ARADDR)
        fcq_pkg::REG_CTRL:      rdata_reg <= 32'(double_reg);
        fcq_pkg::REG_STATUS:    rdata_reg <= status;
        fcq_pkg::REG_EMPTY_OFS: rdata_reg <= 32'(empty_ofs_reg);
        fcq_pkg::REG_FULL_OFS:  rdata_reg <= 32'(full_ofs_reg);
        default:                rdata_reg <= '0;
      endcase
    end else if (rvalid_reg && I_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign O_AXI_BVALID = bvalid_reg;
  assign O_AXI_BRESP  = bresp_reg;
  assign O_AXI_RVALID = rvalid_reg;
  assign O_AXI_RRESP  = rresp_reg;
  assign O_AXI_RDATA  = rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_write_advances: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N) do_write |=> wptr_reg == $past(wptr_reg) + 1'b1)
    else $error("write did not advance the write pointer");
  a_full_blocks: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N) mem_full && !I_WRITE_EN_N |=> $stable(wptr_reg))
    else $error("write pointer moved while full");
  a_output_holds: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N) !fall_through_mode_reg && I_READ_EN_N |=> $stable(out_reg))
    else $error("output register changed without a read");
  a_empty_blocks: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N) !fall_through_mode_reg && mem_empty && I_OFFSET_LOAD_N
    |=> $stable(rptr_reg) && $stable(out_reg))
    else $error("read acted on an empty buffer");
  a_std_no_fall: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N)
    (!fall_through_mode_reg && mem_empty && do_write && I_READ_EN_N) ##1 I_READ_EN_N
    |=> $stable(out_reg))
    else $error("standard mode word appeared without a read");
  a_fall_three: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N)
    fall_through_mode_reg && mem_empty && !out_valid_reg && do_write
    |=> !out_valid_reg [*3] ##1 out_valid_reg)
    else $error("fall-through word not shown after three edges");
  a_offset_load: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N)
    load_wr && ofs_sel_reg == fcq_pkg::FCQ_SEL_EMPTY
    |=> empty_ofs_reg == OW'($past(I_WRITE_DATA)) &&
        ofs_sel_reg == fcq_pkg::FCQ_SEL_FULL)
    else $error("empty offset not loaded from the data inputs");
  a_half_flag: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N)
    (total > QW'(DEPTH / 2)) == !O_HALF_FULL_N)
    else $error("half-full flag disagrees with the count");
  a_almost_empty: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N)
    sync_flags_reg && total <= QW'(empty_ofs_reg) |=> !ae_reg)
    else $error("almost-empty not asserted at the offset");
  a_mode_held: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_ARST_N)
    cfg_done_reg |=> $stable(fall_through_mode_reg) && $stable(sync_flags_reg))
    else $error("mode changed after capture");
endmodule // fcq_fifo
`default_nettype wire

// ### tb/fcq_port_partner.sv
// Writer and reader logic that drives the buffer's two data ports.
`timescale 1ns/1ns
`default_nettype none
module fcq_port_partner (
  // Clock
  input  wire logic                      i_clk,
  // Port drive
  output logic [fcq_pkg::DATA_W-1:0]     o_write_data,
  output logic                           o_write_en_n,
  output logic                           o_offset_load_n,
  output logic                           o_read_en_n
);
  initial begin
    o_write_data    = '0;
    o_write_en_n    = 1'b1;
    o_offset_load_n = 1'b1;
    o_read_en_n     = 1'b1;
  end
  ////////////////////////////////////////
  // The bench calls this only after reset, so no write comes before it.
  // An idle data bus shows the inverse of its last word, never a copy.
  task automatic op(input logic wr, input logic rd, input logic ld,
                    input logic [fcq_pkg::DATA_W-1:0] d);
    @(posedge i_clk);
    o_write_en_n    <= !wr;
    o_read_en_n     <= !rd;
    o_offset_load_n <= !ld;
    o_write_data    <= wr ? d : ~o_write_data;
  endtask
endmodule // fcq_port_partner
`default_nettype wire

// ### tb/fcq_fifo_test.sv
// Self-checking bench for the 18-bit buffer against a queue model.
`timescale 1ns/1ns
`default_nettype none
module fcq_fifo_test;
  localparam int DEPTH = 256;
  logic        clk = 1'b0, arst_n = 1'b0, oe_n = 1'b0, fl_n = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] axwdata = 32'h0, axrdata, st;
  logic        wen_n, ld_n, ren_n, rd_oe, ef, ff, ae_n, af_n, hf_n;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [17:0] wdata, rdata, exp_out, w;
  int          q[$];
  int          ae, af, seq, i, k, mismatches, num_checks;
  int          seed = 32'h288E;

  always #25 clk = ~clk;

  fcq_fifo #(.DEPTH(DEPTH)) dut_u (
    .I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_WRITE_DATA(wdata),
    .I_WRITE_EN_N(wen_n), .I_OFFSET_LOAD_N(ld_n), .I_READ_EN_N(ren_n),
    .I_OUTPUT_EN_N(oe_n), .O_READ_DATA(rdata), .O_READ_DATA_OE(rd_oe),
    .I_FIRST_LOAD_N(fl_n), .I_WRITE_EXPANSION_IN_N(1'b1),
    .I_READ_EXPANSION_IN_N(fl_n), .O_EMPTY_OR_OUTPUT_READY(ef),
    .O_FULL_OR_INPUT_READY(ff), .O_ALMOST_EMPTY_N(ae_n),
    .O_ALMOST_FULL_N(af_n), .O_HALF_FULL_N(hf_n),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
    .I_AXI_WDATA(axwdata), .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wvalid),
    .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid),
    .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
    .O_AXI_ARREADY(arready), .O_AXI_RDATA(axrdata), .O_AXI_RRESP(rresp),
    .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready));
  fcq_port_partner partner_u (.i_clk(clk), .o_write_data(wdata),
    .o_write_en_n(wen_n), .o_offset_load_n(ld_n), .o_read_en_n(ren_n));
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic note(input logic ok, input logic [31:0] g, e);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_data(input logic [17:0] g, e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic cmp_flags(input logic [5:0] g, e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic cmp_bus(input logic [31:0] g, e);
    note(g === e, g, e);
  endtask
  task automatic hung();
    mismatches++;
    wrap_up();
  endtask
  task automatic rst(input logic fl);
    arst_n <= 1'b0;
    fl_n   <= fl;
    repeat (11) @(posedge clk);
    #1;
    cmp_flags({ef, ff, ae_n, af_n, hf_n, rd_oe}, {5'h0B, !oe_n});
    cmp_data(rdata, 18'h0);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    q.delete();
    ae      = 31;
    af      = 31;
    seq     = 0;
    exp_out = 18'h0;
  endtask
  // The model takes each request at call time; the port shows it one edge on.
  task automatic do_op(input logic wr, rd, ld, input logic [17:0] d);
    logic full, emp;
    full = q.size() >= DEPTH;
    emp  = q.size() == 0;
    partner_u.op(wr, rd, ld, d);
    #1;
    cmp_data(rdata, exp_out);
    if (ld && wr) begin
      if (seq == 0) ae = int'(d[11:0]);
      if (seq == 1) af = int'(d[11:0]);
      seq = 1 - seq;
    end else if (ld && rd) begin
      exp_out = 18'(seq == 0 ? ae : af);
      seq     = 1 - seq;
    end else begin
      if (rd && !emp) exp_out = 18'(q.pop_front());
      if (wr && !full) q.push_back(int'(d));
    end
  endtask
  task automatic chk_flags();
    int n;
    logic [5:0] e;
    n = q.size();
    do_op(1'b0, 1'b0, 1'b0, 18'h0);
    @(posedge clk);
    oe_n <= 1'($random(seed));
    repeat (2) @(posedge clk);
    #1;
    e = {n > 0, n < DEPTH, n > ae, DEPTH - n > af, n <= DEPTH / 2, !oe_n};
    cmp_flags({ef, ff, ae_n, af_n, hf_n, rd_oe}, e);
  endtask
  function automatic bit edge_count(input int n);
    return n == 0 || n == ae || n == ae + 1 || n == DEPTH / 2 ||
           n == DEPTH / 2 + 1 || n == DEPTH - af - 1 || n == DEPTH - af;
  endfunction
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    axwdata <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) hung();
    cmp_bus(32'(bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 40) hung();
    cmp_bus(axrdata, e);
    cmp_bus(32'(rresp), 32'(er));
  endtask
  ////////////////////////////////////////
  initial begin
    rst(1'b1);
    axi_rd(fcq_pkg::REG_EMPTY_OFS, 32'h1F, fcq_pkg::RESP_OKAY);
    axi_rd(fcq_pkg::REG_FULL_OFS, 32'h1F, fcq_pkg::RESP_OKAY);
    axi_wr(4'h2, 32'h1, fcq_pkg::RESP_SLVERR);
    axi_rd(4'h2, 32'h0, fcq_pkg::RESP_SLVERR);
    axi_wr(fcq_pkg::REG_CTRL, 32'h1, fcq_pkg::RESP_OKAY);
    axi_rd(fcq_pkg::REG_CTRL, 32'h1, fcq_pkg::RESP_OKAY);
    for (k = 0; k < 4; k++) begin
      w = 18'($random(seed));
      do_op(k < 2, k >= 2, 1'b1, {w[17:12], 7'h0, w[4:0]});
    end
    do_op(1'b0, 1'b0, 1'b0, 18'h0);
    axi_rd(fcq_pkg::REG_EMPTY_OFS, 32'(ae), fcq_pkg::RESP_OKAY);
    axi_rd(fcq_pkg::REG_FULL_OFS, 32'(af), fcq_pkg::RESP_OKAY);
    chk_flags();
    for (k = 0; k < DEPTH * 2 + 3; k++) begin
      do_op(k >= DEPTH * 2 || ($random(seed) & 3) != 0, 1'b0, 1'b0,
            18'($random(seed)));
      if (edge_count(q.size()) || q.size() == DEPTH) chk_flags();
    end
    i  = q.size();
    st = {16'(i), 9'h0, 1'b1, 1'b0, i <= DEPTH / 2, DEPTH - i > af, i > ae,
          i < DEPTH, i > 0};
    axi_rd(fcq_pkg::REG_STATUS, st, fcq_pkg::RESP_OKAY);
    for (k = 0; k < DEPTH * 4 && q.size() > 0; k++) begin
      do_op(1'b0, ($random(seed) & 3) != 0, 1'b0, 18'h0);
      if (edge_count(q.size())) chk_flags();
    end
    repeat (3) do_op(1'b0, 1'b1, 1'b0, 18'h0);
    chk_flags();
    rst(1'b0);
    w = 18'($random(seed));
    partner_u.op(1'b1, 1'b0, 1'b0, w);
    partner_u.op(1'b0, 1'b0, 1'b0, w);
    repeat (3) @(posedge clk);
    #1;
    cmp_data(rdata, w);
    repeat (2) @(posedge clk);
    #1;
    cmp_flags({5'h0, ef}, 6'h01);
    partner_u.op(1'b0, 1'b1, 1'b0, w);
    partner_u.op(1'b0, 1'b0, 1'b0, w);
    repeat (4) @(posedge clk);
    #1;
    cmp_flags({4'h0, ef, ff}, 6'h01);
    axi_rd(fcq_pkg::REG_STATUS, 32'h3A, fcq_pkg::RESP_OKAY);
    wrap_up();
  end
endmodule // fcq_fifo_test
`default_nettype wire
